// ===== inc/sbcir_pkg.sv
// Constants, field layout and bus carrier type for the serial board glue registers
package sbcir_pkg;
  // Address ranges handed out by the bus bridge
  localparam logic [2:0] SHARED_STATUS_RANGE = 3'h0;
  localparam logic [2:0] PORT_ONE_RANGE = 3'h1;
  localparam logic [2:0] PORT_TWO_RANGE = 3'h2;
  localparam logic [2:0] PORT_THREE_RANGE = 3'h3;
  localparam logic [2:0] PORT_FOUR_RANGE = 3'h4;
  localparam int MAX_PORTS = 4;
  // Byte offsets
  localparam logic [7:0] IRQ_CTRL_OFS = 8'h4c;
  localparam logic [2:0] CLKSEL_OFS = 3'h7;
  localparam logic [2:0] UART_LAST_OFS = 3'h6;
  // Interrupt control word fields
  localparam int IRQ_ENABLE_BIT = 0;
  localparam int IRQ_POLARITY_BIT = 1;
  localparam int IRQ_ACTIVE_BIT = 2;
  // Per-port register fields
  localparam int PORT_ONE_IRQ_FLAG = 0;
  localparam int PORT_FOUR_IRQ_FLAG = 3;
  localparam int CLOCK_SELECT_LOW_BIT = 4;
  localparam int CLOCK_SELECT_HIGH_BIT = 5;
  // Values after reset
  localparam logic IRQ_ENABLE_RST = 1'b1;
  localparam logic IRQ_POLARITY_RST = 1'b0;
  localparam logic [1:0] CLKSEL_RST = 2'h0;
  // Clock select codes
  localparam logic [1:0] CLKSEL_1M8432 = 2'h0;
  localparam logic [1:0] CLKSEL_3M6864 = 2'h1;
  localparam logic [1:0] CLKSEL_7M3728 = 2'h2;
  // Reference clock input positions
  localparam int REF_1M8432 = 0;
  localparam int REF_3M6864 = 1;
  localparam int REF_7M3728 = 2;
  // Edges from taking a request to its acknowledge
  localparam int ACK_LATENCY = 2;

  typedef struct packed {
    logic [2:0] range;
    logic [7:0] offset;
    logic rd;
    logic wr;
    logic [31:0] wdata;
  } sbcir_lb_req_t;
endpackage

// ===== verilog/sbcir_top.sv
// Board glue registers: interrupt control, per-port clock select, UART decode
// Contract
// - Control bit 0 enables the board interrupt; comes up enabled.
// - Control bit 1 sets output polarity; 0 active low, the default.
// - Control bit 2 reads 1 while any port interrupt request is active, even with the enable bit clear.
// - Offset 7 read returns all four port interrupt requests in bits 3:0.
// - Offset 7 bits 5:4 hold the port clock select; writes store only these.
// - Select 00, 01, 10 route 1.8432, 3.6864, 7.3728 MHz to the UART.
// - Each port's clock select is independent of the other ports.
// - Offsets 0 to 6 of each port range reach that port's UART bytewise.
// - Besides range 0, only ranges 1 to ports are decoded; port n sits in range n+1.
// - First range is shared interrupt status; ranges 1 to NUM_PORTS hold one port each, ranges above that hold none.
// - Clock select fields start at the slowest setting after reset.
module sbcir_top #(
  parameter int NUM_PORTS = 4
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Bridge local bus
  input wire sbcir_pkg::sbcir_lb_req_t lb_req_in,
  output logic [31:0] lb_rdata_out,
  output logic lb_ack_out,
  // UART cores
  output logic [NUM_PORTS-1:0] uart_sel_out,
  output logic [2:0] uart_addr_out,
  output logic uart_rd_out,
  output logic uart_wr_out,
  output logic [7:0] uart_wdata_out,
  input wire logic [NUM_PORTS-1:0][7:0] uart_rdata_in,
  input wire logic [NUM_PORTS-1:0] uart_irq_in,
  // Reference clocks
  input wire logic [2:0] ref_clk_in,
  output logic [NUM_PORTS-1:0] uart_ref_clk_out,
  // Board interrupt
  output logic board_irq_out
);
  import sbcir_pkg::*;

  sbcir_lb_req_t req_q;
  sbcir_lb_req_t req2_q;
  logic irq_en_q;
  logic irq_pol_q;
  logic [NUM_PORTS-1:0][1:0] clksel_q;
  logic [2:0] ref_meta_q;
  logic [2:0] ref_sync_q;
  logic [3:0] irq_flags;
  logic any_irq;
  logic [31:0] rdata_d;
  logic first_q;

  function automatic logic hit_ctrl(input sbcir_lb_req_t r);
    return (r.range == SHARED_STATUS_RANGE) && (r.offset == IRQ_CTRL_OFS);
  endfunction

  // Ranges past the fitted ports stay undecoded
  function automatic logic hit_port(input sbcir_lb_req_t r);
    return (r.range != SHARED_STATUS_RANGE) && (int'(r.range) <= NUM_PORTS)
      && (r.offset[7:3] == 5'h00);
  endfunction

  function automatic logic [2:0] port_idx(input sbcir_lb_req_t r);
    return 3'(r.range - PORT_ONE_RANGE);
  endfunction

  // Unused flag positions read as zero on smaller boards
  always_comb begin
    irq_flags = 4'h0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      irq_flags[i] = uart_irq_in[i];
    end
  end
  assign any_irq = |irq_flags;

  // Request pipeline: take, act, answer
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_q <= '0;
      req2_q <= '0;
    end else begin
      req_q <= lb_req_in;
      req2_q <= req_q;
    end
  end

  // Upper control bits are not stored here; software masks them
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_en_q <= IRQ_ENABLE_RST;
      irq_pol_q <= IRQ_POLARITY_RST;
    end else if (req_q.wr && hit_ctrl(req_q)) begin
      irq_en_q <= req_q.wdata[IRQ_ENABLE_BIT];
      irq_pol_q <= req_q.wdata[IRQ_POLARITY_BIT];
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      board_irq_out <= !IRQ_POLARITY_RST;
    end else begin
      board_irq_out <= (irq_en_q && any_irq) ? irq_pol_q : !irq_pol_q;
    end
  end

  // Reference clocks come from board oscillators
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ref_meta_q <= 3'h0;
      ref_sync_q <= 3'h0;
    end else begin
      ref_meta_q <= ref_clk_in;
      ref_sync_q <= ref_meta_q;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        clksel_q[i] <= CLKSEL_RST;
      end else if (req_q.wr && hit_port(req_q) && port_idx(req_q) == 3'(i)
                   && req_q.offset[2:0] == CLKSEL_OFS) begin
        clksel_q[i] <= req_q.wdata[CLOCK_SELECT_HIGH_BIT:CLOCK_SELECT_LOW_BIT];
      end
    end

    // Reserved code parks the UART clock low
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        uart_ref_clk_out[i] <= 1'b0;
      end else begin
        case (clksel_q[i])
          CLKSEL_1M8432: uart_ref_clk_out[i] <= ref_sync_q[REF_1M8432];
          CLKSEL_3M6864: uart_ref_clk_out[i] <= ref_sync_q[REF_3M6864];
          CLKSEL_7M3728: uart_ref_clk_out[i] <= ref_sync_q[REF_7M3728];
          default: uart_ref_clk_out[i] <= 1'b0;
        endcase
      end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        uart_sel_out[i] <= 1'b0;
      end else begin
        uart_sel_out[i] <= (req_q.rd || req_q.wr) && hit_port(req_q)
          && port_idx(req_q) == 3'(i) && req_q.offset[2:0] <= UART_LAST_OFS;
      end
    end

    chk_clksel_store: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (req_q.wr && hit_port(req_q) && port_idx(req_q) == 3'(i)
       && req_q.offset[2:0] == CLKSEL_OFS)
      |=> clksel_q[i] == $past(req_q.wdata[CLOCK_SELECT_HIGH_BIT:CLOCK_SELECT_LOW_BIT]))
      else $error("clock select not stored");
    chk_clksel_independent: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (req_q.wr && port_idx(req_q) != 3'(i)) |=> $stable(clksel_q[i]))
      else $error("clock select changed by another port");
    chk_ref_route: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (clksel_q[i] == CLKSEL_7M3728) |=> uart_ref_clk_out[i] == $past(ref_sync_q[REF_7M3728]))
      else $error("fast reference clock not routed");
    chk_uart_decode: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (req_q.rd && hit_port(req_q) && port_idx(req_q) == 3'(i)
       && req_q.offset[2:0] <= UART_LAST_OFS) |=> uart_sel_out[i] && uart_rd_out
       && uart_addr_out == $past(req_q.offset[2:0]))
      else $error("uart access not forwarded");
  end

  // Shared strobes toward the UART cores
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      uart_addr_out <= 3'h0;
      uart_rd_out <= 1'b0;
      uart_wr_out <= 1'b0;
      uart_wdata_out <= 8'h00;
    end else begin
      uart_addr_out <= req_q.offset[2:0];
      uart_rd_out <= req_q.rd && hit_port(req_q) && req_q.offset[2:0] <= UART_LAST_OFS;
      uart_wr_out <= req_q.wr && hit_port(req_q) && req_q.offset[2:0] <= UART_LAST_OFS;
      uart_wdata_out <= req_q.wdata[7:0];
    end
  end

  // Read mux; UART data is taken in the same cycle as its strobe
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_ctrl(req2_q)) begin
      rdata_d[IRQ_ENABLE_BIT] = irq_en_q;
      rdata_d[IRQ_POLARITY_BIT] = irq_pol_q;
      rdata_d[IRQ_ACTIVE_BIT] = any_irq;
    end else if (hit_port(req2_q) && req2_q.offset[2:0] == CLKSEL_OFS) begin
      rdata_d[PORT_FOUR_IRQ_FLAG:PORT_ONE_IRQ_FLAG] = irq_flags;
      rdata_d[CLOCK_SELECT_HIGH_BIT:CLOCK_SELECT_LOW_BIT] = clksel_q[port_idx(req2_q)];
    end else if (hit_port(req2_q)) begin
      rdata_d[7:0] = uart_rdata_in[port_idx(req2_q)];
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lb_rdata_out <= 32'h0000_0000;
      lb_ack_out <= 1'b0;
    end else begin
      lb_rdata_out <= req2_q.rd ? rdata_d : 32'h0000_0000;
      lb_ack_out <= req2_q.rd || req2_q.wr;
    end
  end

  chk_enable_gates_irq: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    !irq_en_q |=> board_irq_out == $past(!irq_pol_q))
    else $error("disabled interrupt still asserted");
  chk_irq_polarity: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (irq_en_q && any_irq) |=> board_irq_out == $past(irq_pol_q))
    else $error("interrupt output polarity wrong");
  chk_active_flag: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (req2_q.rd && hit_ctrl(req2_q)) |=> lb_rdata_out[IRQ_ACTIVE_BIT] == $past(any_irq))
    else $error("interrupt active flag wrong");
  chk_flag_mirror: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (req2_q.rd && hit_port(req2_q) && req2_q.offset[2:0] == CLKSEL_OFS)
    |=> lb_rdata_out[PORT_FOUR_IRQ_FLAG:PORT_ONE_IRQ_FLAG] == $past(irq_flags)
    && lb_rdata_out[7:6] == 2'h0)
    else $error("port interrupt flags not mirrored");
  chk_reserved_zero: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (req2_q.rd && hit_port(req2_q) && req2_q.offset[2:0] == CLKSEL_OFS)
    |=> lb_rdata_out[31:6] == 26'h0)
    else $error("reserved bits not zero");
  chk_unmapped_range: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (lb_req_in.rd && int'(lb_req_in.range) > NUM_PORTS)
    |-> ##2 uart_sel_out == '0 ##1 lb_ack_out && lb_rdata_out == 32'h0)
    else $error("unfitted range decoded");
  chk_shared_range: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (lb_req_in.rd && lb_req_in.range == SHARED_STATUS_RANGE
     && lb_req_in.offset != IRQ_CTRL_OFS)
    |-> ##3 lb_rdata_out == 32'h0)
    else $error("shared range returned data off the control word");
  chk_clksel_reset: assert property (
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    first_q |-> clksel_q == '0)
    else $error("clock select not slowest after reset");
endmodule

// ===== sim/sbcir_uart_model.sv
// UART core stand-in answering forwarded reads with an address-tagged byte
module sbcir_uart_model (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  // Forwarded strobes
  input wire logic [3:0] sel_in,
  input wire logic [2:0] addr_in,
  input wire logic rd_in,
  // Read data back to the glue
  output logic [3:0][7:0] rdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tog_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) tog_q <= 1'b0;
    else tog_q <= ~tog_q;
  end
  // Outside a read the lines change every cycle, so a late sample never matches
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      rdata_out[n] = {2'(n), 3'h0, addr_in};
      if (!(rd_in && sel_in[n])) rdata_out[n] = ~rdata_out[n] ^ (tog_q ? 8'haa : 8'h55);
    end
  end
endmodule

// ===== sim/sbcir_top_test.sv
// Self-checking bench for the serial board glue registers
module sbcir_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sbcir_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  sbcir_lb_req_t lb_req = '0;
  logic [31:0] lb_rdata, d;
  logic lb_ack, uart_rd, uart_wr, board_irq;
  logic [3:0] uart_sel, ref_out;
  logic [3:0] irq = 4'h0;
  logic [2:0] uart_addr, a;
  logic [2:0] ref_clk = 3'h0;
  logic [7:0] uart_wdata;
  logic [3:0][7:0] uart_rdata;
  logic [31:0] q[$];
  logic [1:0] code [4];
  int n_mismatch = 0;
  int total_checks = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  sbcir_top #(.NUM_PORTS(4)) dut_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .lb_req_in(lb_req), .lb_rdata_out(lb_rdata), .lb_ack_out(lb_ack), .uart_sel_out(uart_sel),
    .uart_addr_out(uart_addr), .uart_rd_out(uart_rd), .uart_wr_out(uart_wr),
    .uart_wdata_out(uart_wdata), .uart_rdata_in(uart_rdata), .uart_irq_in(irq),
    .ref_clk_in(ref_clk), .uart_ref_clk_out(ref_out), .board_irq_out(board_irq));
  sbcir_uart_model uart_u (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .sel_in(uart_sel),
    .addr_in(uart_addr), .rd_in(uart_rd), .rdata_out(uart_rdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One-cycle request pulse; the note of its answer is queued at once
  task automatic op(input logic [2:0] rg, input logic [7:0] ofs, input logic w,
                    input logic [31:0] wd, input logic [31:0] exp);
    @(posedge clk_sys_in);
    #1;
    lb_req = '{range: rg, offset: ofs, rd: !w, wr: w, wdata: wd};
    q.push_back(exp);
  endtask
  task automatic idle(input int cyc);
    @(posedge clk_sys_in);
    #1;
    lb_req.rd = 1'b0;
    lb_req.wr = 1'b0;
    repeat (cyc) @(posedge clk_sys_in);
    #1;
  endtask
  function automatic logic [31:0] preg(input int n);
    return {26'h0, code[n], irq};
  endfunction
  always @(negedge clk_sys_in) begin
    if (lb_ack === 1'b1) begin
      if (q.size() == 0) check(32'h1, 32'h0);
      else check(lb_rdata, q.pop_front());
    end
  end
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    void'($urandom(32'hce5c));
    for (int n = 0; n < 4; n++) code[n] = CLKSEL_RST;
    repeat (3) @(posedge clk_sys_in);
    #1;
    reset_n_in = 1'b1;
    check(board_irq, 1'b1);
    op(SHARED_STATUS_RANGE, IRQ_CTRL_OFS, 0, 0, 32'h1);
    for (int n = 0; n < 4; n++) op(3'(n + 1), 8'h07, 0, 0, preg(n));
    idle(3);
    irq = 4'($urandom_range(15, 1));
    // Software writes only the interrupt fields, upper bits masked to zero
    for (int p = 0; p < 4; p++) begin
      op(SHARED_STATUS_RANGE, IRQ_CTRL_OFS, 1, 32'(p), 32'h0);
      op(SHARED_STATUS_RANGE, IRQ_CTRL_OFS, 0, 0, 32'(p) | 32'h4);
      idle(3);
      check(board_irq, logic'(p[0] ? p[1] : !p[1]));
    end
    op(SHARED_STATUS_RANGE, IRQ_CTRL_OFS, 1, 32'h1, 32'h0);
    idle(3);
    irq = 4'h0;
    idle(2);
    check(board_irq, 1'b1);
    irq = 4'($urandom);
    // Junk in bits 7:6 and 3:0 must not stick
    for (int n = 0; n < 4; n++) begin
      code[n] = 2'(n);
      op(3'(n + 1), 8'h07, 1, ($urandom & 32'hcf) | (32'(n) << 4), 0);
    end
    for (int n = 0; n < 4; n++) op(3'(n + 1), 8'h07, 0, 0, preg(n));
    idle(3);
    repeat (8) begin
      ref_clk = 3'($urandom);
      repeat (6) @(posedge clk_sys_in);
      #1;
      for (int n = 0; n < 4; n++) check(ref_out[n], n < 3 ? ref_clk[n] : 1'b0);
    end
    for (int n = 0; n < 4; n++) begin
      a = 3'($urandom_range(6, 0));
      d = $urandom;
      op(3'(n + 1), {5'h0, a}, 0, 0, {24'h0, 2'(n), 3'h0, a});
      op(3'(n + 1), {5'h0, a}, 1, d, 0);
      idle(0);
      @(posedge clk_sys_in);
      #1;
      check({uart_sel, uart_rd, uart_wr, uart_addr, uart_wdata},
            {4'(1 << n), 1'b0, 1'b1, a, d[7:0]});
      idle(2);
    end
    op(SHARED_STATUS_RANGE, 8'h48, 0, 0, 0);
    op(3'h5, 8'h07, 1, 32'h30, 0);
    op(3'h5, 8'h07, 0, 0, 0);
    op(PORT_ONE_RANGE, 8'h0f, 1, 32'h30, 0);
    op(PORT_ONE_RANGE, 8'h07, 0, 0, preg(0));
    idle(3);
    check(q.size(), 0);
    results();
  end
endmodule
